/* logic/prodp_pkg.sv */
// Shared constants and types for the pattern register output path.
// Assumes a sequencer that presents one decoded line per line-clock enable.
package prodp_pkg;
  localparam int BYTE_W = 8;
  localparam int WORD_W = 16;
  localparam logic [7:0]  BYTE_ZERO = 8'h00;
  localparam logic [7:0]  BYTE_ONE  = 8'h01;
  localparam logic [15:0] WORD_ZERO = 16'h0000;
  localparam logic [15:0] WORD_ONE  = 16'h0001;
  // Probe source select carried by each line; the word source drives both ports.
  typedef enum logic [3:0] {
    PRODP_SRC_DATA   = 4'h1,
    PRODP_SRC_FIRST  = 4'h2,
    PRODP_SRC_SECOND = 4'h4,
    PRODP_SRC_WORD   = 4'h8
  } prodp_src_e;
endpackage

/* logic/prodp_down_counter.sv */
// Wrapping down counter with load and hold, used for the low counter half.
// Assumes the caller gates dec with the line enable.
`timescale 1ns/1ps
module prodp_down_counter
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Control
  input  wire logic       load,
  input  wire logic [7:0] load_value,
  input  wire logic       dec,
  input  wire logic       borrow_in,
  // State
  output logic [7:0]      value,
  output logic            borrow_out
);
  // The upper half borrows only when the lower half wraps, so a 16-bit count is two halves.
  assign borrow_out = borrow_in && (value == prodp_pkg::BYTE_ZERO);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      value <= prodp_pkg::BYTE_ZERO;
    else if (load)
      value <= load_value;
    else if (dec && borrow_in)
      value <= value - prodp_pkg::BYTE_ONE;
  end
endmodule // prodp_down_counter

/* logic/prodp_output_path.sv */
// Counter register and probe output datapath of the pattern sequencer.
// Assumes one decoded line per line_en pulse from the sequencer on clk.
// Functional notes
// - Byte counter decrement subtracts one, zero wraps to ff, no borrow flag.
// - Word counter decrement subtracts one, zero wraps to ffff, no borrow flag.
// - Register output replaces the line's programmed data on the probes.
// - Outputting a register never changes its stored value.
// - Byte counter output drives low port only; high port keeps programmed data.
// - Both byte counters output on one line is illegal and rejected.
// - Word output maps msb to high bit 7, lsb to low bit 0.
// - Word output discards both ports' programmed data for that line.
// - Repeat drives low port with previous line's low vector exactly.
// - Repeat leaves high port on current programmed high data.
// - Repeat after word output reproduces only its low eight bits.
// - Step and trace can observe driven outputs and register contents per line.
// - Configuration selects two byte counters or one word; bytes by default.
// - Output and branch test use register value before the line's update.
`timescale 1ns/1ps
module prodp_output_path
(
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  // Configuration
  input  wire logic                   word_mode,
  // Line stream
  input  wire logic                   line_en,
  input  wire logic [7:0]             prog_high,
  input  wire logic [7:0]             prog_low,
  input  wire logic                   load_first,
  input  wire logic                   load_second,
  input  wire logic                   count_down_op_first,
  input  wire logic                   count_down_op_second,
  input  wire logic                   out_first,
  input  wire logic                   out_second,
  input  wire logic                   repeat_last_vector_op,
  // Probe outputs
  output logic [7:0]                  probe_high,
  output logic [7:0]                  probe_low,
  // Trace observation
  output logic                        trace_valid,
  output logic [7:0]                  trace_first_byte_counter,
  output logic [7:0]                  trace_second_byte_counter,
  output logic                        counter_zero,
  output logic                        line_rejected
);
  logic [7:0]  first_byte_counter;
  logic [7:0]  second_byte_counter;
  logic        first_borrow;
  logic        lo_load;
  logic        lo_dec;
  logic        hi_dec;
  logic        bad_line;
  logic        mode_word;
  logic        next_zero;
  logic [7:0]  next_low;
  logic [7:0]  next_high;
  logic [7:0]  last_low;
  prodp_pkg::prodp_src_e src;

  // The configuration is taken only while line_en is low and held while lines run; reset restores byte mode.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      mode_word <= 1'b0;
    else if (!line_en)
      mode_word <= word_mode;
  end

  // A word output needs only out_first; both byte outputs together is a loader fault.
  assign bad_line = line_en && !mode_word && out_first && out_second;

  always_comb
  begin
    if (out_first && mode_word)
      src = prodp_pkg::PRODP_SRC_WORD;
    else if (out_first)
      src = prodp_pkg::PRODP_SRC_FIRST;
    else if (out_second && !mode_word)
      src = prodp_pkg::PRODP_SRC_SECOND;
    else
      src = prodp_pkg::PRODP_SRC_DATA;
  end

  // Outputs are formed from the pre-update counters, which only change at the edge.
  always_comb
  begin
    next_high = prog_high;
    if (repeat_last_vector_op)
      next_low = last_low;
    else
      next_low = prog_low;
    case (src)
      prodp_pkg::PRODP_SRC_FIRST:  next_low = first_byte_counter;
      prodp_pkg::PRODP_SRC_SECOND: next_low = second_byte_counter;
      prodp_pkg::PRODP_SRC_WORD:
      begin
        next_high = second_byte_counter;
        next_low  = first_byte_counter;
      end
      default: ;
    endcase
  end

  assign lo_load = line_en && !bad_line && load_first;
  assign lo_dec = line_en && !bad_line && count_down_op_first && !load_first;
  // In word mode the upper half loads with load_first, so load_second must not block it.
  assign hi_dec = line_en && !bad_line && !(mode_word ? load_first : load_second)
                  && (mode_word ? count_down_op_first : count_down_op_second);

  // The low half lives in the counter instance; its borrow feeds the upper half in word mode only.
  prodp_down_counter u_lo
  (
    .clk        (clk),
    .rst_n      (rst_n),
    .load       (lo_load),
    .load_value (prog_low),
    .dec        (lo_dec),
    .borrow_in  (1'b1),
    .value      (first_byte_counter),
    .borrow_out (first_borrow)
  );

  logic hi_borrow_in;
  assign hi_borrow_in = mode_word ? first_borrow : 1'b1;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      second_byte_counter <= prodp_pkg::BYTE_ZERO;
    else if (line_en && !bad_line && (mode_word ? load_first : load_second))
      second_byte_counter <= mode_word ? prog_high : prog_low;
    else if (hi_dec && hi_borrow_in)
      second_byte_counter <= second_byte_counter - prodp_pkg::BYTE_ONE;
  end

  always_comb
  begin
    if (mode_word)
      next_zero = (first_byte_counter == prodp_pkg::BYTE_ZERO)
                  && (second_byte_counter == prodp_pkg::BYTE_ZERO);
    else
      next_zero = (first_byte_counter == prodp_pkg::BYTE_ZERO);
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      probe_high <= prodp_pkg::BYTE_ZERO;
      probe_low  <= prodp_pkg::BYTE_ZERO;
      last_low   <= prodp_pkg::BYTE_ZERO;
    end
    else if (line_en && !bad_line)
    begin
      probe_high <= next_high;
      probe_low  <= next_low;
      last_low   <= next_low;
    end
  end

  // Trace shows the register as the line saw it, before its own update.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      trace_valid               <= 1'b0;
      trace_first_byte_counter  <= prodp_pkg::BYTE_ZERO;
      trace_second_byte_counter <= prodp_pkg::BYTE_ZERO;
      counter_zero              <= 1'b0;
      line_rejected             <= 1'b0;
    end
    else
    begin
      trace_valid   <= line_en && !bad_line;
      line_rejected <= bad_line;
      if (line_en && !bad_line)
      begin
        trace_first_byte_counter  <= first_byte_counter;
        trace_second_byte_counter <= second_byte_counter;
        counter_zero              <= next_zero;
      end
    end
  end

  AST_WRAP_FIRST: assert property (@(posedge clk) disable iff (!rst_n)
    lo_dec && !mode_word && first_byte_counter == prodp_pkg::BYTE_ZERO
    |=> first_byte_counter == 8'hff)
    else $error("first counter did not wrap to ff");
  AST_WORD_WRAP: assert property (@(posedge clk) disable iff (!rst_n)
    lo_dec && mode_word && next_zero
    |=> {second_byte_counter, first_byte_counter} == 16'hffff)
    else $error("word counter did not wrap to ffff");
  AST_OUT_FIRST: assert property (@(posedge clk) disable iff (!rst_n)
    line_en && !bad_line && src == prodp_pkg::PRODP_SRC_FIRST
    |=> probe_low == $past(first_byte_counter))
    else $error("low probe not first counter");
  AST_OUT_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
    line_en && out_first && !count_down_op_first && !load_first && !load_second
    && !count_down_op_second |=> $stable(first_byte_counter) && $stable(second_byte_counter))
    else $error("output changed register");
  AST_HIGH_KEEP: assert property (@(posedge clk) disable iff (!rst_n)
    line_en && !bad_line && src != prodp_pkg::PRODP_SRC_WORD |=> probe_high == $past(prog_high))
    else $error("high probe not programmed data");
  AST_REJECT: assert property (@(posedge clk) disable iff (!rst_n)
    bad_line |=> line_rejected && !trace_valid && $stable(probe_low))
    else $error("illegal line not rejected");
  AST_WORD_MAP: assert property (@(posedge clk) disable iff (!rst_n)
    line_en && src == prodp_pkg::PRODP_SRC_WORD
    |=> {probe_high, probe_low} == $past({second_byte_counter, first_byte_counter}))
    else $error("word output map wrong");
  AST_REPEAT: assert property (@(posedge clk) disable iff (!rst_n)
    line_en && !bad_line ##1 (line_en && repeat_last_vector_op && !out_first && !out_second)
    |=> probe_low == $past(probe_low) && probe_high == $past(prog_high))
    else $error("repeat vector wrong");
  AST_DEFAULT_MODE: assert property (@(posedge clk)
    $rose(rst_n) |-> !mode_word)
    else $error("mode not bytes after reset");

  COV_WORD_OUT: cover property (@(posedge clk) disable iff (!rst_n)
    line_en && src == prodp_pkg::PRODP_SRC_WORD);
  COV_REPEAT: cover property (@(posedge clk) disable iff (!rst_n)
    line_en && repeat_last_vector_op);
  COV_WRAP: cover property (@(posedge clk) disable iff (!rst_n)
    lo_dec && first_byte_counter == prodp_pkg::BYTE_ZERO);
  COV_REJECT: cover property (@(posedge clk) disable iff (!rst_n) bad_line);
endmodule // prodp_output_path

/* tb/prodp_probe_model.sv */
// Probe-side model: latches the vector driven to the system under test per line.
// Assumes trace_valid marks the cycle in which the probes hold a new line's vector.
`timescale 1ns/1ps
module prodp_probe_model
(
  // Clock
  input  wire logic       clk,
  // Probe pins
  input  wire logic       trace_valid,
  input  wire logic [7:0] probe_high,
  input  wire logic [7:0] probe_low,
  // Captured vector
  output logic      [7:0] cap_high,
  output logic      [7:0] cap_low
);
  // The probes only listen, so nothing is driven back toward the block.
  always_ff @(posedge clk)
  begin
    if (trace_valid)
    begin
      cap_high <= probe_high;
      cap_low  <= probe_low;
    end
  end
endmodule // prodp_probe_model

/* tb/prodp_output_path_tb_top.sv */
// Self-checking bench for the pattern register output path.
// Assumes the package, the design and the probe model are compiled first.
`timescale 1ns/1ps
module prodp_output_path_tb_top;
  localparam logic [6:0] LD1 = 7'h40;
  localparam logic [6:0] LD2 = 7'h20;
  localparam logic [6:0] DN1 = 7'h10;
  localparam logic [6:0] DN2 = 7'h08;
  localparam logic [6:0] OU1 = 7'h04;
  localparam logic [6:0] OU2 = 7'h02;
  localparam logic [6:0] REP = 7'h01;
  logic       clk       = 1'b0;
  logic       rst_n     = 1'b0;
  logic       word_mode = 1'b0;
  logic       line_en   = 1'b0;
  logic [7:0] prog_high = 8'h00;
  logic [7:0] prog_low  = 8'h00;
  logic [6:0] op        = 7'h00;
  logic [7:0] probe_high, probe_low, tr_first, tr_second, cap_high, cap_low;
  logic       trace_valid, counter_zero, line_rejected;
  int         fails           = 0;
  int         samples_checked = 0;

  always #10 clk = ~clk;

  prodp_output_path prodp_output_path_i (.clk(clk), .rst_n(rst_n), .word_mode(word_mode),
    .line_en(line_en), .prog_high(prog_high), .prog_low(prog_low), .load_first(op[6]),
    .load_second(op[5]), .count_down_op_first(op[4]), .count_down_op_second(op[3]),
    .out_first(op[2]), .out_second(op[1]), .repeat_last_vector_op(op[0]),
    .probe_high(probe_high), .probe_low(probe_low), .trace_valid(trace_valid),
    .trace_first_byte_counter(tr_first), .trace_second_byte_counter(tr_second),
    .counter_zero(counter_zero), .line_rejected(line_rejected));

  prodp_probe_model prodp_probe_model_i (.clk(clk), .trace_valid(trace_valid),
    .probe_high(probe_high), .probe_low(probe_low), .cap_high(cap_high), .cap_low(cap_low));

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Line enable stays high between calls, so back-to-back lines are exercised.
  task automatic line(input logic [7:0] h, input logic [7:0] l, input logic [6:0] o);
    prog_high = h;
    prog_low  = l;
    op        = o;
    line_en   = 1'b1;
    @(negedge clk);
  endtask

  task automatic idle;
    line_en = 1'b0;
    @(negedge clk);
  endtask

  task automatic t_bytes;
    line(8'h11, 8'h00, LD1);
    line(8'h22, 8'h05, LD2);
    line(8'h33, 8'h00, DN1 | DN2 | OU1);
    chk(16'(probe_low), 16'h0000);
    chk(16'(probe_high), 16'h0033);
    chk(16'({tr_second, tr_first}), 16'h0500);
    chk(16'(trace_valid), 16'h0001);
    line(8'h44, 8'haa, OU1);
    chk(16'(probe_low), 16'h00ff);
    line(8'h55, 8'haa, OU2);
    chk(16'(probe_low), 16'h0004);
    line(8'h66, 8'haa, OU1);
    chk(16'(probe_low), 16'h00ff);
    line(8'h77, 8'hbb, OU1 | OU2);
    chk(16'(line_rejected), 16'h0001);
    chk(16'(trace_valid), 16'h0000);
    chk(16'({probe_high, probe_low}), 16'h66ff);
    line(8'h88, 8'hcc, REP);
    chk(16'({probe_high, probe_low}), 16'h88ff);
    line(8'h99, 8'hcc, REP);
    chk(16'(probe_low), 16'h00ff);
    line(8'h12, 8'h3c, 7'h00);
    chk(16'(probe_low), 16'h003c);
    line(8'h13, 8'h00, REP);
    chk(16'(probe_low), 16'h003c);
    idle();
  endtask

  task automatic t_word;
    word_mode = 1'b1;
    idle();
    line(8'h12, 8'h34, LD1);
    line(8'haa, 8'h55, OU1 | DN1);
    chk(16'({probe_high, probe_low}), 16'h1234);
    chk(16'({tr_second, tr_first}), 16'h1234);
    line(8'h00, 8'h00, LD1);
    line(8'h00, 8'h00, DN1);
    chk(16'(counter_zero), 16'h0001);
    line(8'h01, 8'h02, OU1);
    chk(16'({probe_high, probe_low}), 16'hffff);
    line(8'h5a, 8'h00, REP);
    chk(16'({probe_high, probe_low}), 16'h5aff);
    idle();
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial
  begin
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    t_bytes();
    t_word();
    idle();
    chk(16'({cap_high, cap_low}), 16'h5aff);
    end_of_test();
  end

  // The sequence needs under 60 cycles; this bound leaves wide margin.
  initial
  begin
    #20000;
    fails++;
    end_of_test();
  end
endmodule // prodp_output_path_tb_top
